// [rtl/dma_alias_irq_pkg.sv]
// package: register map, field layout and carrier types of the alias trigger and interrupt block
package dma_alias_irq_pkg;

    localparam int          NUM_CH_DEF   = 12;
    localparam int          IRQ_W        = 16;
    localparam int          ADDR_W       = 12;
    localparam int          CH_SHIFT     = 6;

    // offsets inside one channel's 0x40 window
    localparam logic [5:0]  A2_CTRL      = 6'h20;
    localparam logic [5:0]  A2_COUNT     = 6'h24;
    localparam logic [5:0]  A2_SRC       = 6'h28;
    localparam logic [5:0]  A2_DST_TRIG  = 6'h2c;
    localparam logic [5:0]  A3_CTRL      = 6'h30;
    localparam logic [5:0]  A3_DST       = 6'h34;
    localparam logic [5:0]  A3_COUNT     = 6'h38;
    localparam logic [5:0]  A3_SRC_TRIG  = 6'h3c;

    localparam logic [11:0] OFF_RAW      = 12'h400;
    localparam logic [11:0] OFF_EN0      = 12'h404;
    localparam logic [11:0] OFF_F0       = 12'h408;
    localparam logic [11:0] OFF_S0       = 12'h40c;
    localparam logic [11:0] OFF_EN1      = 12'h414;
    localparam logic [11:0] OFF_F1       = 12'h418;
    localparam logic [11:0] OFF_S1       = 12'h41c;

    localparam logic [31:0] CHAN_RST     = 32'h0000_0000;
    localparam logic [15:0] IRQ_RST      = 16'h0000;
    localparam logic [15:0] RSVD_HI      = 16'h0000;

    typedef enum logic [1:0] {
        F_CTRL  = 2'b00,
        F_COUNT = 2'b01,
        F_SRC   = 2'b10,
        F_DST   = 2'b11
    } field_t;

    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_CHAN = 4'h1,
        K_RAW  = 4'h2,
        K_EN0  = 4'h3,
        K_F0   = 4'h4,
        K_S0   = 4'h5,
        K_EN1  = 4'h6,
        K_F1   = 4'h7,
        K_S1   = 4'h8
    } kind_t;

    typedef struct packed {
        kind_t      kind;
        logic [3:0] ch;
        field_t     fld;
        logic       trig;
    } dec_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] count;
        logic [31:0] src;
        logic [31:0] dst;
    } chan_regs_t;

endpackage

// [rtl/dma_alias_trigger_and_irq_regs.sv]
// module: apb register slave for alias sets two/three with triggers, and dual irq aggregation
//
// Functional notes
// - alias set two per channel at 0x020 + n*0x40: control, count, source, destination-trigger.
// - alias two destination register at 0x02c + n*0x40 stores destination and starts channel.
// - alias set three at 0x030 + n*0x40: control, destination, count, source-trigger.
// - alias three source register at 0x03c + n*0x40 stores source and starts channel.
// - nonzero trigger write reloads counter and starts channel; zero write only stores.
// - alias sets two and three share one storage per channel; non-trigger aliases only store.
// - raw pending at 0x400, bit n per channel, ignores enables and forces.
// - writing a mask to raw or either masked status clears those pending bits.
// - irq0 enable at 0x404 gates channel n onto irq0; resets to zero.
// - irq0 force at 0x408 holds requests toward irq0 until software clears it.
// - irq0 masked status at 0x40c shows requests currently driving irq0.
// - irq1 enable at 0x414 gates channel n onto irq1; resets to zero.
// - irq1 force at 0x418 holds requests toward irq1 until software clears it.
// - irq1 masked status at 0x41c shows irq1 drivers; mask write clears pending.
`timescale 1ns/100ps
`default_nettype none

module dma_alias_trigger_and_irq_regs #(
    parameter int NUM_CH = dma_alias_irq_pkg::NUM_CH_DEF
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic                                pready,
    output var logic [31:0]                     prdata,
    output logic                                pslverr,
    input  wire logic [dma_alias_irq_pkg::IRQ_W-1:0] chan_done,
    output var dma_alias_irq_pkg::chan_regs_t   chan_cfg_r [NUM_CH],
    output var logic [NUM_CH-1:0]               chan_start_r,
    output logic                                irq0,
    output logic                                irq1
);

    localparam int IW = dma_alias_irq_pkg::IRQ_W;

    dma_alias_irq_pkg::dec_t d;
    logic                    wr_en;
    logic                    rd_setup;
    logic [IW-1:0]           pend_r;
    logic [IW-1:0]           en0_r;
    logic [IW-1:0]           f0_r;
    logic [IW-1:0]           en1_r;
    logic [IW-1:0]           f1_r;
    logic [IW-1:0]           masked0;
    logic [IW-1:0]           masked1;
    logic [IW-1:0]           clr_mask;

    // one aligned word per register; low address bits ignored
    function automatic dma_alias_irq_pkg::dec_t decode(input logic [31:0] a);
        dma_alias_irq_pkg::dec_t r;
        r.kind = dma_alias_irq_pkg::K_NONE;
        r.ch   = a[dma_alias_irq_pkg::CH_SHIFT +: 4];
        r.fld  = dma_alias_irq_pkg::F_CTRL;
        r.trig = 1'b0;
        if (a[31:10] == 22'h0 && 32'(r.ch) < NUM_CH) begin
            r.kind = dma_alias_irq_pkg::K_CHAN;
            unique case ({a[5:2], 2'b00})
                dma_alias_irq_pkg::A2_CTRL:     r.fld = dma_alias_irq_pkg::F_CTRL;
                dma_alias_irq_pkg::A2_COUNT:    r.fld = dma_alias_irq_pkg::F_COUNT;
                dma_alias_irq_pkg::A2_SRC:      r.fld = dma_alias_irq_pkg::F_SRC;
                dma_alias_irq_pkg::A2_DST_TRIG: begin
                    r.fld  = dma_alias_irq_pkg::F_DST;
                    r.trig = 1'b1;
                end
                dma_alias_irq_pkg::A3_CTRL:     r.fld = dma_alias_irq_pkg::F_CTRL;
                dma_alias_irq_pkg::A3_DST:      r.fld = dma_alias_irq_pkg::F_DST;
                dma_alias_irq_pkg::A3_COUNT:    r.fld = dma_alias_irq_pkg::F_COUNT;
                dma_alias_irq_pkg::A3_SRC_TRIG: begin
                    r.fld  = dma_alias_irq_pkg::F_SRC;
                    r.trig = 1'b1;
                end
                default:                        r.kind = dma_alias_irq_pkg::K_NONE;
            endcase
        end else if (a[31:12] == 20'h0) begin
            unique case ({a[11:2], 2'b00})
                dma_alias_irq_pkg::OFF_RAW: r.kind = dma_alias_irq_pkg::K_RAW;
                dma_alias_irq_pkg::OFF_EN0: r.kind = dma_alias_irq_pkg::K_EN0;
                dma_alias_irq_pkg::OFF_F0:  r.kind = dma_alias_irq_pkg::K_F0;
                dma_alias_irq_pkg::OFF_S0:  r.kind = dma_alias_irq_pkg::K_S0;
                dma_alias_irq_pkg::OFF_EN1: r.kind = dma_alias_irq_pkg::K_EN1;
                dma_alias_irq_pkg::OFF_F1:  r.kind = dma_alias_irq_pkg::K_F1;
                dma_alias_irq_pkg::OFF_S1:  r.kind = dma_alias_irq_pkg::K_S1;
                default:                    r.kind = dma_alias_irq_pkg::K_NONE;
            endcase
        end
        return r;
    endfunction

    function automatic logic [31:0] zext(input logic [IW-1:0] v);
        return {dma_alias_irq_pkg::RSVD_HI, v};
    endfunction

    assign d        = decode(paddr);
    // zero wait states: the access phase always completes in one cycle
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite && d.kind != dma_alias_irq_pkg::K_NONE;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr  = psel && penable && d.kind == dma_alias_irq_pkg::K_NONE;

    assign masked0  = (pend_r | f0_r) & en0_r;
    assign masked1  = (pend_r | f1_r) & en1_r;
    assign irq0     = |masked0;
    assign irq1     = |masked1;

    always_comb begin
        clr_mask = '0;
        if (wr_en && (d.kind == dma_alias_irq_pkg::K_RAW || d.kind == dma_alias_irq_pkg::K_S0
                      || d.kind == dma_alias_irq_pkg::K_S1)) begin
            clr_mask = pwdata[IW-1:0];
        end
    end

    // channel storage; pstrb not honoured, every write stores a whole word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chan_cfg_r[i] <= '{default: dma_alias_irq_pkg::CHAN_RST};
            end
        end else if (wr_en && d.kind == dma_alias_irq_pkg::K_CHAN) begin
            unique case (d.fld)
                dma_alias_irq_pkg::F_CTRL:  chan_cfg_r[d.ch].ctrl  <= pwdata;
                dma_alias_irq_pkg::F_COUNT: chan_cfg_r[d.ch].count <= pwdata;
                dma_alias_irq_pkg::F_SRC:   chan_cfg_r[d.ch].src   <= pwdata;
                dma_alias_irq_pkg::F_DST:   chan_cfg_r[d.ch].dst   <= pwdata;
            endcase
        end
    end

    // start pulse also tells the datapath to reload its counter from count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chan_start_r <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                chan_start_r[i] <= wr_en && d.kind == dma_alias_irq_pkg::K_CHAN && d.trig
                                   && 32'(d.ch) == i && pwdata != 32'h0000_0000;
            end
        end
    end

    // a completion in the same cycle as a clear survives
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_r <= dma_alias_irq_pkg::IRQ_RST;
        end else begin
            pend_r <= (pend_r & ~clr_mask) | chan_done;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en0_r <= dma_alias_irq_pkg::IRQ_RST;
            f0_r  <= dma_alias_irq_pkg::IRQ_RST;
            en1_r <= dma_alias_irq_pkg::IRQ_RST;
            f1_r  <= dma_alias_irq_pkg::IRQ_RST;
        end else if (wr_en) begin
            if (d.kind == dma_alias_irq_pkg::K_EN0) en0_r <= pwdata[IW-1:0];
            if (d.kind == dma_alias_irq_pkg::K_F0)  f0_r  <= pwdata[IW-1:0];
            if (d.kind == dma_alias_irq_pkg::K_EN1) en1_r <= pwdata[IW-1:0];
            if (d.kind == dma_alias_irq_pkg::K_F1)  f1_r  <= pwdata[IW-1:0];
        end
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (d.kind)
                dma_alias_irq_pkg::K_CHAN: begin
                    unique case (d.fld)
                        dma_alias_irq_pkg::F_CTRL:  prdata <= chan_cfg_r[d.ch].ctrl;
                        dma_alias_irq_pkg::F_COUNT: prdata <= chan_cfg_r[d.ch].count;
                        dma_alias_irq_pkg::F_SRC:   prdata <= chan_cfg_r[d.ch].src;
                        dma_alias_irq_pkg::F_DST:   prdata <= chan_cfg_r[d.ch].dst;
                    endcase
                end
                dma_alias_irq_pkg::K_RAW:  prdata <= zext(pend_r);
                dma_alias_irq_pkg::K_EN0:  prdata <= zext(en0_r);
                dma_alias_irq_pkg::K_F0:   prdata <= zext(f0_r);
                dma_alias_irq_pkg::K_S0:   prdata <= zext(masked0);
                dma_alias_irq_pkg::K_EN1:  prdata <= zext(en1_r);
                dma_alias_irq_pkg::K_F1:   prdata <= zext(f1_r);
                dma_alias_irq_pkg::K_S1:   prdata <= zext(masked1);
                dma_alias_irq_pkg::K_NONE: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks on storage, triggers and interrupt state
    logic wr_chan;
    assign wr_chan = wr_en && d.kind == dma_alias_irq_pkg::K_CHAN;

    AST_A2_DST_TRIG: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A2_DST_TRIG && pwdata != 32'h0
        |=> chan_cfg_r[$past(d.ch)].dst == $past(pwdata) && chan_start_r[$past(d.ch)])
        else $error("alias two destination trigger did not store and start");

    AST_A3_SRC_TRIG: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A3_SRC_TRIG && pwdata != 32'h0
        |=> chan_cfg_r[$past(d.ch)].src == $past(pwdata) && chan_start_r[$past(d.ch)])
        else $error("alias three source trigger did not store and start");

    AST_A3_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A3_COUNT
        |=> chan_cfg_r[$past(d.ch)].count == $past(pwdata))
        else $error("alias three count write misrouted");

    AST_A2_CTRL: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A2_CTRL
        |=> chan_cfg_r[$past(d.ch)].ctrl == $past(pwdata))
        else $error("alias two control write misrouted");

    AST_NO_START: assert property (@(posedge clk_sys) disable iff (rst)
        !(wr_chan && d.trig && pwdata != 32'h0) |=> chan_start_r == '0)
        else $error("channel started without nonzero trigger write");

    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
        $past(chan_done) != '0 |-> (pend_r & $past(chan_done)) == $past(chan_done))
        else $error("completion lost against a clear");

    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_S1 && chan_done == '0
        |=> (pend_r & $past(pwdata[IW-1:0])) == '0)
        else $error("masked status write did not clear pending");

    AST_FORCE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        !(wr_en && (d.kind == dma_alias_irq_pkg::K_F0 || d.kind == dma_alias_irq_pkg::K_F1))
        |=> f0_r == $past(f0_r) && f1_r == $past(f1_r))
        else $error("force bits changed without a write");

    AST_IRQ0_SRC: assert property (@(posedge clk_sys) disable iff (rst)
        (chan_done & en0_r) != '0 && !(wr_en && d.kind == dma_alias_irq_pkg::K_EN0) |=> irq0)
        else $error("irq0 low after an enabled completion");

    AST_RESET_VAL: assert property (@(posedge clk_sys)
        rst |=> en0_r == '0 && en1_r == '0 && f0_r == '0 && f1_r == '0 && pend_r == '0 && !irq0 && !irq1)
        else $error("interrupt state not zero after reset");

    AST_RAW_READ: assert property (@(posedge clk_sys) disable iff (rst)
        rd_setup && d.kind == dma_alias_irq_pkg::K_RAW
        |=> prdata == {dma_alias_irq_pkg::RSVD_HI, $past(pend_r)})
        else $error("raw status read wrong or reserved bits set");

    AST_A2_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A2_COUNT
        |=> chan_cfg_r[$past(d.ch)].count == $past(pwdata))
        else $error("alias two count write misrouted");

    AST_A2_SRC: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A2_SRC
        |=> chan_cfg_r[$past(d.ch)].src == $past(pwdata) && chan_start_r == '0)
        else $error("alias two source write misrouted or started a channel");

    AST_A3_CTRL: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A3_CTRL
        |=> chan_cfg_r[$past(d.ch)].ctrl == $past(pwdata))
        else $error("alias three control write misrouted");

    AST_A3_DST: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A3_DST
        |=> chan_cfg_r[$past(d.ch)].dst == $past(pwdata) && chan_start_r == '0)
        else $error("alias three destination write misrouted or started a channel");

    AST_TRIG_ONE: assert property (@(posedge clk_sys) disable iff (rst)
        wr_chan && d.trig && pwdata != 32'h0 |=> $onehot(chan_start_r))
        else $error("trigger write did not start exactly one channel");

    AST_EN0_WR: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_EN0 |=> en0_r == $past(pwdata[IW-1:0]))
        else $error("irq0 enable write not stored");

    AST_EN1_WR: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_EN1 |=> en1_r == $past(pwdata[IW-1:0]))
        else $error("irq1 enable write not stored");

    AST_F0_WR: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_F0 |=> f0_r == $past(pwdata[IW-1:0]))
        else $error("irq0 force write not stored");

    AST_F1_WR: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_F1 |=> f1_r == $past(pwdata[IW-1:0]))
        else $error("irq1 force write not stored");

    AST_S0_READ: assert property (@(posedge clk_sys) disable iff (rst)
        rd_setup && d.kind == dma_alias_irq_pkg::K_S0
        |=> prdata == {dma_alias_irq_pkg::RSVD_HI, $past((pend_r | f0_r) & en0_r)})
        else $error("irq0 masked status read wrong");

    AST_S1_READ: assert property (@(posedge clk_sys) disable iff (rst)
        rd_setup && d.kind == dma_alias_irq_pkg::K_S1
        |=> prdata == {dma_alias_irq_pkg::RSVD_HI, $past((pend_r | f1_r) & en1_r)})
        else $error("irq1 masked status read wrong");

    AST_IRQ1_SRC: assert property (@(posedge clk_sys) disable iff (rst)
        (chan_done & en1_r) != '0 && !(wr_en && d.kind == dma_alias_irq_pkg::K_EN1) |=> irq1)
        else $error("irq1 low after an enabled completion");

    AST_FORCE0_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        (f0_r & en0_r) != '0 |-> irq0)
        else $error("forced and enabled request not on irq0");

    AST_FORCE1_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        (f1_r & en1_r) != '0 |-> irq1)
        else $error("forced and enabled request not on irq1");

    AST_CLEAR_RAW: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_RAW && chan_done == '0
        |=> (pend_r & $past(pwdata[IW-1:0])) == '0)
        else $error("raw status write did not clear pending");

    AST_CLEAR_S0: assert property (@(posedge clk_sys) disable iff (rst)
        wr_en && d.kind == dma_alias_irq_pkg::K_S0 && chan_done == '0
        |=> (pend_r & $past(pwdata[IW-1:0])) == '0)
        else $error("irq0 masked status write did not clear pending");

    AST_PEND_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
        chan_done == '0 && clr_mask == '0 |=> pend_r == $past(pend_r))
        else $error("pending changed with no completion and no clear");

    AST_BAD_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        psel && penable && pwrite && d.kind == dma_alias_irq_pkg::K_NONE
        |=> $stable(en0_r) && $stable(en1_r) && $stable(f0_r) && $stable(f1_r) && chan_start_r == '0)
        else $error("write to an unmapped address changed state");

    COV_TRIG_A2: cover property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A2_DST_TRIG && pwdata != 32'h0);
    COV_TRIG_A3: cover property (@(posedge clk_sys) disable iff (rst)
        wr_chan && paddr[5:0] == dma_alias_irq_pkg::A3_SRC_TRIG && pwdata != 32'h0);
    COV_IRQ1_FORCE: cover property (@(posedge clk_sys) disable iff (rst) irq1 && pend_r == '0);
    COV_SET_CLR: cover property (@(posedge clk_sys) disable iff (rst) (clr_mask & chan_done) != '0);
    COV_BOTH_IRQ: cover property (@(posedge clk_sys) disable iff (rst) irq0 && irq1);

endmodule

`default_nettype wire

// [sim/done_source_model.sv]
// partner model: channel datapath that reports completion a fixed time after each start
`timescale 1ns/100ps
`default_nettype none

module done_source_model #(
    parameter int NUM_CH = 12,
    parameter int DLY    = 3
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [NUM_CH-1:0] chan_start_r,
    output logic      [15:0]       chan_done
);
    // a start strobe travels down a short delay line and comes back as a done pulse
    logic [15:0] pipe_r [DLY];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < DLY; i++) begin
                pipe_r[i] <= 16'h0000;
            end
        end else begin
            pipe_r[0] <= 16'(chan_start_r);
            for (int i = 1; i < DLY; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    assign chan_done = pipe_r[DLY-1];
endmodule

`default_nettype wire

// [sim/testbench.sv]
// testbench: apb scenarios for alias triggers and irq aggregation
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int NCH = 12;
    logic                          clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq0, irq1;
    logic [31:0]                   paddr, pwdata, prdata;
    logic [3:0]                    pstrb;
    logic [15:0]                   chan_done;
    dma_alias_irq_pkg::chan_regs_t chan_cfg_r [NCH];
    logic [NCH-1:0]                chan_start_r;
    int                            n_mismatch, checks_done;

    dma_alias_trigger_and_irq_regs #(.NUM_CH(NCH)) i_dma_alias_trigger_and_irq_regs (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .chan_done(chan_done), .chan_cfg_r(chan_cfg_r),
        .chan_start_r(chan_start_r), .irq0(irq0), .irq1(irq1));

    done_source_model #(.NUM_CH(NCH), .DLY(3)) i_done_source_model (
        .clk_sys(clk_sys), .rst(rst), .chan_start_r(chan_start_r), .chan_done(chan_done));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task wrap_up;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request is held until pready is seen high
    task acc(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic eerr,
             output logic [31:0] rd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        chk(32'(pslverr), 32'(eerr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        acc(1'b0, a, 32'h0, 1'b0, r);
        chk(r, exp);
    endtask

    // write, then expect the given start pulse for exactly one cycle
    task wt(input logic [31:0] a, input logic [31:0] d, input logic [NCH-1:0] st);
        logic [31:0] r;
        acc(1'b1, a, d, 1'b0, r);
        #1;
        chk(32'(chan_start_r), 32'(st));
        @(posedge clk_sys);
        #1;
        chk(32'(chan_start_r), 32'h0);
    endtask

    task t_reset;
        for (int i = 0; i < 8; i++) begin
            if (i != 4) rchk(32'h400 + 32'(4 * i), 32'h0);
        end
        chk(32'({irq1, irq0}), 32'h0);
    endtask

    task t_alias;
        logic [31:0] b;
        for (int k = 0; k < 2; k++) begin
            b = 32'(k * 11 * 64);
            wt(b + 32'h20, 32'h1111_0001 + b, 12'h000);
            wt(b + 32'h24, 32'h2222_0002 + b, 12'h000);
            wt(b + 32'h28, 32'h3333_0003 + b, 12'h000);
            wt(b + 32'h34, 32'h4444_0004 + b, 12'h000);
            rchk(b + 32'h30, 32'h1111_0001 + b);
            rchk(b + 32'h38, 32'h2222_0002 + b);
            rchk(b + 32'h28, 32'h3333_0003 + b);
            rchk(b + 32'h2c, 32'h4444_0004 + b);
            chk(chan_cfg_r[k*11].dst, 32'h4444_0004 + b);
        end
    endtask

    task t_trigger;
        wt(32'h06c, 32'h0000_0005, 12'h002);
        chk(chan_cfg_r[1].dst, 32'h0000_0005);
        wt(32'h06c, 32'h0000_0000, 12'h000);
        wt(32'h2fc, 32'h0000_0abc, 12'h800);
        chk(chan_cfg_r[11].src, 32'h0000_0abc);
        wt(32'h03c, 32'h0000_0000, 12'h000);
        repeat (8) @(posedge clk_sys);
        rchk(32'h400, 32'h0000_0802);
    endtask

    task t_irq;
        wt(32'h400, 32'hffff_ffff, 12'h000);
        rchk(32'h400, 32'h0);
        wt(32'h0ac, 32'h0000_0001, 12'h004);
        wt(32'h17c, 32'h0000_0001, 12'h020);
        repeat (8) @(posedge clk_sys);
        chk(32'({irq1, irq0}), 32'h0);
        rchk(32'h400, 32'h0000_0024);
        wt(32'h404, 32'hffff_0004, 12'h000);
        rchk(32'h404, 32'h0000_0004);
        wt(32'h414, 32'h0000_0020, 12'h000);
        chk(32'({irq1, irq0}), 32'h3);
        rchk(32'h40c, 32'h0000_0004);
        rchk(32'h41c, 32'h0000_0020);
        wt(32'h40c, 32'h0000_0004, 12'h000);
        chk(32'({irq1, irq0}), 32'h2);
        wt(32'h41c, 32'h0000_0020, 12'h000);
        chk(32'({irq1, irq0}), 32'h0);
        rchk(32'h400, 32'h0);
        wt(32'h408, 32'h0000_0080, 12'h000);
        chk(32'({irq1, irq0}), 32'h0);
        wt(32'h404, 32'h0000_0080, 12'h000);
        chk(32'({irq1, irq0}), 32'h1);
        rchk(32'h40c, 32'h0000_0080);
        rchk(32'h400, 32'h0);
        wt(32'h40c, 32'h0000_0080, 12'h000);
        chk(32'({irq1, irq0}), 32'h1);
        wt(32'h408, 32'h0, 12'h000);
        chk(32'({irq1, irq0}), 32'h0);
        wt(32'h418, 32'hffff_0020, 12'h000);
        chk(32'({irq1, irq0}), 32'h2);
        rchk(32'h418, 32'h0000_0020);
        rchk(32'h41c, 32'h0000_0020);
        wt(32'h418, 32'h0, 12'h000);
        chk(32'({irq1, irq0}), 32'h0);
    endtask

    task t_unmapped;
        logic [31:0] r;
        acc(1'b0, 32'h410, 32'h0, 1'b1, r);
        chk(r, 32'h0);
        acc(1'b1, 32'h004, 32'h1, 1'b1, r);
        acc(1'b0, 32'h320, 32'h0, 1'b1, r);
    endtask

    // completions while both lines are enabled, then a reset in mid-run
    task t_live;
        wt(32'h404, 32'h0000_0008, 12'h000);
        wt(32'h414, 32'h0000_0008, 12'h000);
        wt(32'h0ec, 32'h0000_0077, 12'h008);
        repeat (6) @(posedge clk_sys);
        chk(32'({irq1, irq0}), 32'h3);
        rchk(32'h40c, 32'h0000_0008);
        rchk(32'h41c, 32'h0000_0008);
        wt(32'h400, 32'h0000_0008, 12'h000);
        chk(32'({irq1, irq0}), 32'h0);
        wt(32'h418, 32'h0000_0001, 12'h000);
        wt(32'h414, 32'h0000_0001, 12'h000);
        chk(32'({irq1, irq0}), 32'h2);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(32'({irq1, irq0}), 32'h0);
        rchk(32'h418, 32'h0);
        rchk(32'h414, 32'h0);
        rchk(32'h0ec, 32'h0);
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_alias();
        t_trigger();
        t_irq();
        t_unmapped();
        t_live();
        wrap_up();
    end
endmodule

`default_nettype wire
